/* File: rtl/adc_decim_pkg.sv */
/*
  Shared constants and types for the two-channel decimator path.
  Assumes a 32-bit APB register bus and one 250 MHz clock.
*/
package adc_decim_pkg;
  // Register byte addresses
  localparam logic [31:0] SIO_CFG_ADDR    = 32'h8020_0384;
  localparam logic [31:0] AIN_CTRL_ADDR   = 32'h8020_03A4;
  localparam logic [31:0] CONV_CTRL_ADDR  = 32'h8020_03A8;
  localparam logic [31:0] DEC_CTRL_ADDR   = 32'h8020_03AC;
  localparam logic [31:0] DEC_STAT_ADDR   = 32'h8020_03B0;
  localparam logic [31:0] LEFT24_ADDR     = 32'h8020_03B4;
  localparam logic [31:0] RIGHT24_ADDR    = 32'h8020_03B8;
  localparam logic [31:0] PAIR16_ADDR     = 32'h8020_03BC;
  // Reset values
  localparam logic [31:0] SIO_CFG_RST     = 32'h0000_0180;
  localparam logic [31:0] AIN_CTRL_RST    = 32'h0000_0000;
  localparam logic [31:0] CONV_CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] DEC_CTRL_RST    = 32'h0000_0000;
  // Decimator control fields
  localparam int RIGHT_DIGITAL_GAIN_LSB   = 0;
  localparam int LEFT_DIGITAL_GAIN_LSB   = 8;
  localparam int INVERT_BIT  = 17;
  localparam int MUTE_BIT    = 18;
  localparam int OUT_DC_BIT  = 19;
  localparam int IN_DC_BIT   = 20;
  // Decimator status fields
  localparam int STAT_OVR_BIT   = 0;
  localparam int STAT_AVAIL_BIT = 1;
  localparam int STAT_FULL_BIT  = 2;
  // Stream and arithmetic constants
  localparam int OVERSAMPLE      = 128;
  localparam int SAMPLE_W        = 24;
  localparam int READ16_W        = 16;
  localparam int BIT_DIV_DEF     = 8;
  localparam int DC_SHIFT        = 10;
  localparam int BUF_DEPTH       = 2;
  localparam logic signed [7:0] GAIN_MAX_CODE = 8'sh30;
  localparam logic signed [8:0] GAIN_BIAS     = 9'sh090;
  localparam logic [7:0] GAIN_STEPS   = 8'h0C;
  localparam logic [5:0] GAIN_SHIFT0  = 6'h1B;

  typedef struct packed {
    logic [SAMPLE_W-1:0] left;
    logic [SAMPLE_W-1:0] right;
  } sample_pair_t;

  typedef struct packed {
    logic [7:0] gain;
    logic       invert;
    logic       mute;
    logic       in_dc_en;
    logic       out_dc_en;
  } chan_ctrl_t;
endpackage : adc_decim_pkg

/* File: rtl/sample_pair_buffer.sv */
/*
  Small flip-flop FIFO with valid/ready on both sides.
  Assumes the reader may stall; a full buffer drops in_ready.
*/
`timescale 1ns/1ns
`default_nettype none
module sample_pair_buffer #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 2
) (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  full
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      wp_nxt;
  logic [AW:0]      rp_r;
  logic [AW:0]      rp_nxt;
  logic             wr;
  logic             rd;

  // Pointer arithmetic and flags
  always_comb begin
    full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    out_valid = (wp_r != rp_r);
    in_ready  = !full;
    wr        = in_valid && in_ready;
    rd        = out_valid && out_ready;
    wp_nxt    = wr ? wp_r + 1'b1 : wp_r;
    rp_nxt    = rd ? rp_r + 1'b1 : rp_r;
    out_data  = mem_r[rp_r[AW-1:0]];
  end

  // Pointer registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage, written only on an accepted word
  always_ff @(posedge ref_clk) begin
    if (wr) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end
endmodule : sample_pair_buffer
`default_nettype wire

/* File: rtl/decim_channel.sv */
/*
  One decimator channel: 128:1 boxcar, DC blockers, gain, mute.
  Assumes bit_en and frame_end come from the shared stream counter.
*/
`timescale 1ns/1ns
`default_nettype none
module decim_channel
  import adc_decim_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 bit_en,
  input  wire logic                 bit_in,
  input  wire logic                 frame_end,
  input  wire adc_decim_pkg::chan_ctrl_t ctrl,
  output logic [SAMPLE_W-1:0]       sample_r,
  output logic                      valid_r
);
  logic        [7:0]  cnt_r, cnt_nxt, tot;
  logic signed [9:0]  cen;
  logic signed [23:0] raw, x1, x2, dci_r, dci_nxt, dco_r, dco_nxt;
  logic signed [23:0] gsat, y, smp_nxt;
  logic signed [7:0]  gc;
  logic        [7:0]  idx;
  logic        [4:0]  q;
  logic        [3:0]  rsel;
  logic        [15:0] mant;
  logic signed [40:0] prod, shv;

  // Half-dB mantissas, Q1.15
  function automatic logic [15:0] mant_lut(input logic [3:0] r);
    case (r)
      4'h0: mant_lut = 16'h8000;  4'h1: mant_lut = 16'h879C;
      4'h2: mant_lut = 16'h8F9D;  4'h3: mant_lut = 16'h9838;
      4'h4: mant_lut = 16'hA145;  4'h5: mant_lut = 16'hAADC;
      4'h6: mant_lut = 16'hB505;  4'h7: mant_lut = 16'hBFC9;
      4'h8: mant_lut = 16'hCB30;  4'h9: mant_lut = 16'hD745;
      4'hA: mant_lut = 16'hE412;  4'hB: mant_lut = 16'hF1A2;
      default: mant_lut = 16'h8000;
    endcase
  endfunction : mant_lut

  // Datapath from bit count to output sample
  always_comb begin
    tot     = cnt_r + {7'h00, bit_en & bit_in};                 // R02
    cnt_nxt = frame_end ? 8'h00 : tot;
    cen     = $signed({1'b0, tot, 1'b0}) - 10'sd128;
    raw     = {cen[8:0], 15'h0000};                             // R03
    x1      = ctrl.in_dc_en ? raw - dci_r : raw;                // R04
    dci_nxt = ctrl.in_dc_en ? dci_r + (x1 >>> DC_SHIFT) : '0;
    x2      = ctrl.invert ? -x1 : x1;                           // R10
    gc      = ($signed(ctrl.gain) > GAIN_MAX_CODE) ?
              GAIN_MAX_CODE : $signed(ctrl.gain);               // R09
    idx     = 8'($signed({gc[7], gc}) + GAIN_BIAS);
    q       = 5'(idx / GAIN_STEPS);
    rsel    = 4'(idx % GAIN_STEPS);
    mant    = mant_lut(rsel);
    prod    = 41'(x2 * $signed({1'b0, mant}));                  // R05
    shv     = prod >>> (GAIN_SHIFT0 - {1'b0, q});
    if (shv > 41'sh7FFFFF)        gsat = 24'sh7FFFFF;
    else if (shv < -41'sh800000)  gsat = -24'sh800000;
    else                          gsat = shv[23:0];
    y       = ctrl.out_dc_en ? gsat - dco_r : gsat;             // R04
    dco_nxt = ctrl.out_dc_en ? dco_r + (y >>> DC_SHIFT) : '0;
    smp_nxt = ctrl.mute ? '0 : y;                               // R10
  end

  // Counter every bit, filter state and sample once per frame
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r    <= '0;
      dci_r    <= '0;
      dco_r    <= '0;
      sample_r <= '0;
      valid_r  <= 1'b0;
    end else begin
      if (bit_en) cnt_r <= cnt_nxt;
      if (frame_end) begin
        dci_r    <= dci_nxt;
        dco_r    <= dco_nxt;
        sample_r <= smp_nxt;
      end
      valid_r <= frame_end;
    end
  end

  property p_mute;
    @(posedge ref_clk) disable iff (!rstn)
    frame_end && ctrl.mute |=> valid_r && sample_r == '0;
  endproperty
  a_mute: assert property (p_mute) else $error("mute not zero"); // R10

  property p_unity;
    @(posedge ref_clk) disable iff (!rstn)
    frame_end && ctrl.gain == 8'h00 && !ctrl.in_dc_en && !ctrl.out_dc_en
      && !ctrl.mute && !ctrl.invert |=> sample_r == $past(raw);
  endproperty
  a_unity: assert property (p_unity) else $error("gain 0 not unity"); // R05

  property p_gain_idx;
    @(posedge ref_clk) disable iff (!rstn)
    idx >= 8'h11 && idx <= 8'hC0;
  endproperty
  a_gain_idx: assert property (p_gain_idx) else $error("gain index"); // R09
endmodule : decim_channel
`default_nettype wire

/* File: rtl/dual_adc_decimator.sv */
/*
  Two-channel decimator path with APB registers and sample buffer.
  Assumes modulator bits synchronous to ref_clk, taken on bit_strobe.
*/
// The APB interface to the registers was left to the implementer.
// Contract
// [R01] Both channels sampled in lockstep
// [R02] Decimators take 128x oversampled bitstreams
// [R03] One 24-bit sample per channel per period
// [R04] DC blockers at decimator input and output
// [R05] Programmable digital gain per channel
// [R06] Samples readable as 16 or 24 bits
// [R07] Samples pass through a drainable FIFO buffer
// [R08] Status register read-only, zero after reset
// [R09] Gain signed half-dB, saturating at +24 dB
// [R10] Bits for DC filters, invert, mute
// [R11] Sample pair pushed together once per period
`timescale 1ns/1ns
`default_nettype none
module dual_adc_decimator
  import adc_decim_pkg::*;
#(
  parameter int BIT_DIV = BIT_DIV_DEF
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mod_left,
  input  wire logic        mod_right,
  output logic             bit_strobe,
  output logic             dma_req,
  output logic [31:0]      analog_input_control,
  output logic [31:0]      converter_control
);
  import adc_decim_pkg::*;

  if (BIT_DIV < 1) begin : g_chk
    $error("BIT_DIV must be at least 1");
  end

  localparam int DW = (BIT_DIV > 1) ? $clog2(BIT_DIV) : 1;
  localparam logic [DW-1:0] DIV_LAST = DW'(BIT_DIV - 1);
  localparam logic [6:0]    BIT_LAST = 7'(OVERSAMPLE - 1);

  logic [DW-1:0] div_r, div_nxt;
  logic [6:0]    bit_cnt_r, bit_cnt_nxt;
  logic          bit_en, frame_end;

  // Shared bit divider and frame counter keep channels in step
  always_comb begin
    bit_en      = (div_r == DIV_LAST);
    div_nxt     = bit_en ? '0 : div_r + 1'b1;
    frame_end   = bit_en && (bit_cnt_r == BIT_LAST);          // R02
    bit_cnt_nxt = bit_en ? bit_cnt_r + 1'b1 : bit_cnt_r;
    bit_strobe  = bit_en;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      div_r     <= '0;
      bit_cnt_r <= '0;
    end else begin
      div_r     <= div_nxt;
      bit_cnt_r <= bit_cnt_nxt;
    end
  end

  logic [31:0] sio_r, sio_nxt, ain_r, ain_nxt;
  logic [31:0] conv_r, conv_nxt, dec_r, dec_nxt;
  chan_ctrl_t  ctl_l, ctl_r;

  // Per-channel control split from the decimator control word
  always_comb begin
    ctl_l.gain      = dec_r[LEFT_DIGITAL_GAIN_LSB +: 8];
    ctl_r.gain      = dec_r[RIGHT_DIGITAL_GAIN_LSB +: 8];
    ctl_l.invert    = dec_r[INVERT_BIT];                      // R10
    ctl_l.mute      = dec_r[MUTE_BIT];
    ctl_l.in_dc_en  = dec_r[IN_DC_BIT];
    ctl_l.out_dc_en = dec_r[OUT_DC_BIT];
    ctl_r.invert    = dec_r[INVERT_BIT];
    ctl_r.mute      = dec_r[MUTE_BIT];
    ctl_r.in_dc_en  = dec_r[IN_DC_BIT];
    ctl_r.out_dc_en = dec_r[OUT_DC_BIT];
  end

  logic [SAMPLE_W-1:0] smp_l, smp_r;
  logic                val_l, val_r;

  // Both channels share bit_en and frame_end
  decim_channel u_left (                                      // R01
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .bit_en    (bit_en),
    .bit_in    (mod_left),
    .frame_end (frame_end),
    .ctrl      (ctl_l),
    .sample_r  (smp_l),
    .valid_r   (val_l)
  );

  decim_channel u_right (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .bit_en    (bit_en),
    .bit_in    (mod_right),
    .frame_end (frame_end),
    .ctrl      (ctl_r),
    .sample_r  (smp_r),
    .valid_r   (val_r)
  );

  sample_pair_t in_pair, head;
  logic         push, buf_in_ready, buf_out_valid, buf_full, pop;

  // One write strobe carries the pair
  always_comb begin
    in_pair.left  = smp_l;
    in_pair.right = smp_r;
    push          = val_l && val_r;                           // R11
  end

  sample_pair_buffer #(
    .WIDTH (2 * SAMPLE_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (                                                   // R07
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   (in_pair),
    .out_valid (buf_out_valid),
    .out_ready (pop),
    .out_data  (head),
    .full      (buf_full)
  );

  logic        setup, access, rd_acc, wr_acc;
  logic        ovr_r, ovr_nxt, ovr_set, ovr_clr;
  logic        err_r, err_nxt, head_ok_r;
  logic [31:0] prdata_r, rd_nxt, stat_w, pair16_w;
  logic        hit_rw, hit_ro;

  // APB decode; data captured in setup, used in access
  always_comb begin
    setup    = psel && !penable;
    access   = psel && penable;
    rd_acc   = access && !pwrite;
    wr_acc   = access && pwrite;
    pready   = penable;
    pslverr  = penable && err_r;
    prdata   = prdata_r;
    stat_w   = '0;
    stat_w[STAT_OVR_BIT]   = ovr_r;
    stat_w[STAT_AVAIL_BIT] = buf_out_valid;
    stat_w[STAT_FULL_BIT]  = buf_full;
    pair16_w = {head.right[SAMPLE_W-1 -: READ16_W],
                head.left[SAMPLE_W-1 -: READ16_W]};          // R06
    hit_rw   = paddr == SIO_CFG_ADDR || paddr == AIN_CTRL_ADDR ||
               paddr == CONV_CTRL_ADDR || paddr == DEC_CTRL_ADDR;
    hit_ro   = paddr == DEC_STAT_ADDR || paddr == LEFT24_ADDR ||
               paddr == RIGHT24_ADDR || paddr == PAIR16_ADDR;
    err_nxt  = setup ? !(hit_rw || hit_ro) : err_r;
    case (paddr)
      SIO_CFG_ADDR:   rd_nxt = sio_r;
      AIN_CTRL_ADDR:  rd_nxt = ain_r;
      CONV_CTRL_ADDR: rd_nxt = conv_r;
      DEC_CTRL_ADDR:  rd_nxt = dec_r;
      DEC_STAT_ADDR:  rd_nxt = stat_w;                        // R08
      LEFT24_ADDR:    rd_nxt = buf_out_valid ?
                        32'($signed(head.left)) : '0;         // R06
      RIGHT24_ADDR:   rd_nxt = buf_out_valid ?
                        32'($signed(head.right)) : '0;
      PAIR16_ADDR:    rd_nxt = buf_out_valid ? pair16_w : '0;
      default:        rd_nxt = '0;
    endcase
    if (!setup) rd_nxt = prdata_r;
  end

  // Reads of right or pair words drain the buffer
  always_comb begin
    pop     = rd_acc && head_ok_r &&
              (paddr == RIGHT24_ADDR || paddr == PAIR16_ADDR); // R07
    ovr_set = push && !buf_in_ready;
    ovr_clr = rd_acc && paddr == DEC_STAT_ADDR;
    ovr_nxt = ovr_set || (ovr_r && !ovr_clr);
    sio_nxt  = (wr_acc && paddr == SIO_CFG_ADDR)   ? pwdata : sio_r;
    ain_nxt  = (wr_acc && paddr == AIN_CTRL_ADDR)  ? pwdata : ain_r;
    conv_nxt = (wr_acc && paddr == CONV_CTRL_ADDR) ? pwdata : conv_r;
    dec_nxt  = (wr_acc && paddr == DEC_CTRL_ADDR)  ? pwdata : dec_r;
    analog_input_control = ain_r;
    converter_control    = conv_r;
    dma_req              = buf_out_valid;
  end

  // Register file; status has no writable storage
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sio_r     <= SIO_CFG_RST;
      ain_r     <= AIN_CTRL_RST;
      conv_r    <= CONV_CTRL_RST;
      dec_r     <= DEC_CTRL_RST;
      ovr_r     <= 1'b0;                                      // R08
      err_r     <= 1'b0;
      head_ok_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      sio_r     <= sio_nxt;
      ain_r     <= ain_nxt;
      conv_r    <= conv_nxt;
      dec_r     <= dec_nxt;
      ovr_r     <= ovr_nxt;
      err_r     <= err_nxt;
      head_ok_r <= setup ? buf_out_valid : head_ok_r;
      prdata_r  <= rd_nxt;
    end
  end

  property p_lockstep;
    @(posedge ref_clk) disable iff (!rstn)
    frame_end |=> val_l && val_r;
  endproperty
  a_lockstep: assert property (p_lockstep) else $error("lockstep"); // R01

  property p_frame_gap;
    @(posedge ref_clk) disable iff (!rstn)
    frame_end |=> !frame_end [*8];
  endproperty
  a_frame_gap: assert property (p_frame_gap) else $error("gap"); // R02

  property p_one_per_frame;
    @(posedge ref_clk) disable iff (!rstn)
    frame_end |=> val_l ##1 !val_l;
  endproperty
  a_one_per_frame: assert property (p_one_per_frame)
    else $error("one sample per frame"); // R03

  property p_stat_ro;
    @(posedge ref_clk) disable iff (!rstn)
    wr_acc && paddr == DEC_STAT_ADDR |=>
      ovr_r == $past(ovr_r) || $past(ovr_set);
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("status written"); // R08

  property p_overrun;
    @(posedge ref_clk) disable iff (!rstn)
    push && !buf_in_ready |=> ovr_r;
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost"); // R07

  property p_pop_ok;
    @(posedge ref_clk) disable iff (!rstn)
    pop |-> buf_out_valid;
  endproperty
  a_pop_ok: assert property (p_pop_ok) else $error("pop empty"); // R07

  property p_pair_push;
    @(posedge ref_clk) disable iff (!rstn)
    push && buf_in_ready |=> dma_req;
  endproperty
  a_pair_push: assert property (p_pair_push) else $error("push lost"); // R11

  property p_read16;
    @(posedge ref_clk) disable iff (!rstn)
    setup && !pwrite && paddr == PAIR16_ADDR && buf_out_valid |=>
      prdata == $past(pair16_w);
  endproperty
  a_read16: assert property (p_read16) else $error("16-bit read"); // R06
endmodule : dual_adc_decimator
`default_nettype wire

/* File: testbench/sample_reader.sv */
/*
  Processor model that drains the sample buffer over APB.
  Assumes zero or more wait states; idle gap set by the bench.
*/
`timescale 1ns/1ns
`default_nettype none
module sample_reader (
  input  wire logic        ref_clk,
  output logic [31:0]      paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int gap;

  // Bus idle at time zero
  initial begin
    paddr   = '0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = '0;
    gap     = 0;
  end

  // One transfer; slow reader when gap is large
  task automatic xfer(input logic wr, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    repeat (gap + 1) @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // Only the bench watchdog ends a stuck wait
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : sample_reader
`default_nettype wire

/* File: testbench/testbench.sv */
/*
  Self-checking bench for the two-channel decimator path.
  Assumes a processor model on APB and periodic modulator patterns.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import adc_decim_pkg::*;
  localparam int FRAME = 256;     // 128 bits at two clocks per bit
  logic        ref_clk;
  logic        rstn;
  wire  [31:0] paddr;
  wire  [31:0] pwdata;
  wire  [31:0] prdata;
  wire  [31:0] ain_ctl;
  wire  [31:0] conv_ctl;
  wire         psel, penable, pwrite, pready, pslverr;
  wire         bit_strobe, dma_req;
  logic        mod_left, mod_right;
  int          cnt, kl, kr, failures, checks, i, n;
  logic [31:0] d, g1;
  logic        e;
  typedef struct { int kl; int kr; logic [31:0] ctl, l, r; } row_t;
  row_t rows[4] = '{'{128, 0, 32'h0, 32'h0040_0000, 32'hFFC0_0000},
                    '{96, 32, 32'h0, 32'h0020_0000, 32'hFFE0_0000},
                    '{64, 80, 32'h0002_0000, 32'h0, 32'hFFF0_0000},
                    '{100, 20, 32'h0004_0000, 32'h0, 32'h0}};

  dual_adc_decimator #(.BIT_DIV(2)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mod_left(mod_left),
    .mod_right(mod_right), .bit_strobe(bit_strobe), .dma_req(dma_req),
    .analog_input_control(ain_ctl), .converter_control(conv_ctl));

  sample_reader u_reader (
    .ref_clk(ref_clk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  // Clock, 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Periodic bit patterns: k ones in every 128 consecutive bits
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) cnt <= 0;
    else if (bit_strobe) cnt <= (cnt == 127) ? 0 : cnt + 1;
  end
  assign mod_left  = (cnt < kl);
  assign mod_right = (cnt < kr);

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic rd(input logic [31:0] a, output logic [31:0] v);
    logic x;
    u_reader.xfer(1'b0, a, 32'h0, v, x);
  endtask : rd

  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    logic [31:0] y;
    logic x;
    u_reader.xfer(1'b1, a, v, y, x);
  endtask : wr

  // Empty the buffer, then wait for a fresh pair
  task automatic drain_wait;
    logic [31:0] s;
    int m;
    rd(DEC_STAT_ADDR, s);
    m = 0;
    while (s[STAT_AVAIL_BIT] === 1'b1 && m < 4) begin
      rd(RIGHT24_ADDR, s);
      rd(DEC_STAT_ADDR, s);
      m++;
    end
    m = 0;
    while (dma_req !== 1'b1 && m < 600) begin
      @(posedge ref_clk);
      m++;
    end
    if (m == 600) begin
      failures++;
      $display("ERROR dma_req expected 1 seen 0");
    end
  endtask : drain_wait

  // New settings, three steady frames, then a fresh pair
  task automatic settle(input logic [31:0] ctl, input int l, input int r);
    wr(DEC_CTRL_ADDR, ctl);
    kl <= l;
    kr <= r;
    repeat (3 * FRAME) @(posedge ref_clk);
    drain_wait();
  endtask : settle

  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test

  // Watchdog
  initial begin
    #160000;
    failures++;
    end_of_test();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    kl = 0;
    kr = 0;
    failures = 0;
    checks = 0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    // Reset values and read-only status
    rd(DEC_STAT_ADDR, d); check("status_rst", d, 32'h0);
    wr(DEC_STAT_ADDR, 32'hFFFF_FFFF);
    rd(DEC_STAT_ADDR, d); check("status_ro", d, 32'h0);
    rd(SIO_CFG_ADDR, d); check("sio_rst", d, SIO_CFG_RST);
    rd(AIN_CTRL_ADDR, d); check("ain_rst", d, AIN_CTRL_RST);
    rd(CONV_CTRL_ADDR, d); check("conv_rst", d, CONV_CTRL_RST);
    rd(DEC_CTRL_ADDR, d); check("dec_rst", d, DEC_CTRL_RST);
    wr(AIN_CTRL_ADDR, 32'h0007_1234);
    wr(CONV_CTRL_ADDR, 32'h0000_00A5);
    rd(AIN_CTRL_ADDR, d); check("ain_rw", d, 32'h0007_1234);
    check("ain_port", ain_ctl, 32'h0007_1234);
    check("conv_port", conv_ctl, 32'h0000_00A5);
    u_reader.xfer(1'b0, 32'h8020_0390, 32'h0, d, e);
    check("unmapped_err", e, 1'b1);
    check("unmapped_data", d, 32'h0);
    // Modulator bit rate: 128 bits per frame
    n = 0;
    repeat (FRAME) begin
      @(posedge ref_clk);
      if (bit_strobe === 1'b1) n++;
    end
    check("bits_per_frame", n, 128);
    // Ordinary cases
    for (i = 0; i < 4; i++) begin
      settle(rows[i].ctl, rows[i].kl, rows[i].kr);
      rd(LEFT24_ADDR, d); check("left24", d, rows[i].l);
      rd(RIGHT24_ADDR, d); check("right24", d, rows[i].r);
      rd(DEC_STAT_ADDR, d); check("one_pair", d[STAT_AVAIL_BIT], 1'b0);
      drain_wait();
      rd(PAIR16_ADDR, d);
      check("pair16", d, {rows[i].r[23:8], rows[i].l[23:8]});
    end
    // Slow reader: buffer fills, refuses, then drains
    u_reader.gap = 20;
    wr(DEC_CTRL_ADDR, 32'h0);
    repeat (3 * FRAME) @(posedge ref_clk);
    rd(DEC_STAT_ADDR, d); check("full_ovr", d, 32'h7);
    rd(RIGHT24_ADDR, d);
    rd(DEC_STAT_ADDR, d); check("ovr_clear", d, 32'h2);
    rd(RIGHT24_ADDR, d);
    rd(DEC_STAT_ADDR, d); check("empty", d, 32'h0);
    check("dma_idle", dma_req, 1'b0);
    u_reader.gap = 0;
    // Gain saturates above +24 dB
    settle(32'h0000_3000, 66, 64);
    rd(LEFT24_ADDR, g1);
    check("gain_up", g1 > 32'h0002_0000, 1'b1);
    settle(32'h0000_7F00, 66, 64);
    rd(LEFT24_ADDR, d); check("gain_sat", d, g1);
    // DC blockers pull a constant input below full scale
    settle(32'h0018_0000, 128, 64);
    rd(LEFT24_ADDR, d); check("dc_block", d < 32'h0040_0000, 1'b1);
    // Reset in mid-run: control and status back to reset values
    @(posedge ref_clk);
    rstn <= 1'b0;
    repeat (10) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(DEC_CTRL_ADDR, d); check("dec_rst2", d, DEC_CTRL_RST);
    rd(DEC_STAT_ADDR, d); check("status_rst2", d, 32'h0);
    check("dma_rst2", dma_req, 1'b0);
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
